/* verilog/idle_priority_defines.svh */
// Register offsets, field positions, reset values and timing codes for the idle and priority timers.
// Included by the design modules; holds definitions only.
`ifndef IDLE_PRIORITY_DEFINES_SVH
`define IDLE_PRIORITY_DEFINES_SVH
`define POWER_MGMT_CONTROL_OFFSET 12'h000
`define PRIORITY_RAISE_CONFIG_OFFSET 12'h004
`define POWER_MGMT_CONTROL_MASK 32'h0000_F7F0
`define PRIORITY_RAISE_CONFIG_MASK 32'h00FF_FFFF
`define POWER_MGMT_CONTROL_RESET 32'h0000_0000
`define PRIORITY_RAISE_CONFIG_RESET 32'h00FF_FFFF
`define SELF_REFRESH_TIMER_LSB 4
`define POWER_DOWN_TIMER_LSB 12
`define POWER_DOWN_TIMER_RESET 4'h0
`define LOW_POWER_SELECT_RESET 3'h0
`define SELF_REFRESH_TIMER_RESET 4'h0
`define RAISE_INTERVAL_RESET 8'hFF
`define LP_SEL_LSB 8
`define CLASS1_LSB 16
`define CLASS2_LSB 8
`define OLDEST_LSB 0
`define LP_SELF_REFRESH 3'h2
`define LP_POWER_DOWN 3'h4
`define RAISE_SCALE 4
`define IDLE_CODE10_CLOCKS 19'h022D0
`endif

/* verilog/idle_priority_pkg.sv */
// Types shared by the idle and priority timer design.
// Assumes the defines header sits on the include path.
package idle_priority_pkg;
	typedef enum logic [1:0] {
		sr_active,
		sr_counting,
		sr_in_self_refresh
	} sr_state_e;
	typedef logic [18:0] idle_count_t;
	typedef logic [11:0] raise_count_t;
endpackage : idle_priority_pkg

/* verilog/raise_timer.sv */
// One periodic priority raise timer: pulses every interval*16 clocks.
// Assumes the interval is stable or that a change may restart the count.
`timescale 1ns/1ps
`include "idle_priority_defines.svh"
module raise_timer
	import idle_priority_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [7:0] interval,
	output logic raise
);
	raise_count_t count;
	raise_count_t limit;
	assign limit = {interval, 4'h0};
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count <= 12'h000;
			raise <= 1'b0;
		end else if (limit == 12'h000) begin
			count <= 12'h000;
			raise <= 1'b0;
		end else if (count >= limit - 12'h001) begin
			count <= 12'h000;
			raise <= 1'b1;
		end else begin
			count <= count + 12'h001;
			raise <= 1'b0;
		end
	end
endmodule : raise_timer

/* verilog/idle_priority_timers.sv */
// APB register slave with self-refresh idle timer and three priority raise timers.
// Assumes APB master in pclk domain; controller_idle is a level from the controller core.
`timescale 1ns/1ps
`include "idle_priority_defines.svh"
module idle_priority_timers
	import idle_priority_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic controller_idle,
	output logic self_refresh_req,
	output logic power_down_sel,
	output logic class1_raise,
	output logic class2_raise,
	output logic oldest_raise
);
	logic [31:0] power_mgmt_control;
	logic [31:0] priority_raise_config;
	logic [3:0] self_refresh_idle_timer;
	logic [2:0] low_power_select;
	logic [7:0] class1_raise_interval;
	logic [7:0] class2_raise_interval;
	logic [7:0] oldest_raise_interval;
	logic wr_en;
	logic rd_en;
	logic hit_pm;
	logic hit_pr;
	logic sr_selected;
	idle_count_t idle_count;
	idle_count_t idle_limit;
	sr_state_e sr_state;
	sr_state_e next_sr_state;
	logic [3:0] power_down_timer;
	logic [31:0] pm_merged;
	logic [31:0] pr_merged;
	logic pm_write;
	logic pr_write;
	logic setup_read;
	idle_count_t idle_target;

	// Decode a self-refresh idle code into a clock count
	function automatic idle_count_t idle_clocks(input logic [3:0] code);
		idle_count_t result;
		result = 19'h00000;
		if (code == 4'hA) begin
			result = `IDLE_CODE10_CLOCKS;
		end else if (code != 4'h0) begin
			result = idle_count_t'(19'h00008 << code);
		end
		return result;
	endfunction : idle_clocks

	// Apply byte strobes and a writable mask to a register
	function automatic logic [31:0] merge_write(input logic [31:0] old, input logic [31:0] data,
		input logic [3:0] strb, input logic [31:0] mask);
		logic [31:0] result;
		result = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				result[i*8 +: 8] = data[i*8 +: 8];
			end
		end
		return result & mask;
	endfunction : merge_write

	// True when the address selects the given register offset
	function automatic logic offset_hit(input logic [11:0] addr, input logic [11:0] offset);
		return addr == offset;
	endfunction : offset_hit

	// Build the power control image from its stored fields
	function automatic logic [31:0] pm_image(
		input logic [3:0] pd,
		input logic [2:0] lp,
		input logic [3:0] sr
	);
		logic [31:0] result;
		result = 32'h0000_0000;
		result[`POWER_DOWN_TIMER_LSB +: 4] = pd;
		result[`LP_SEL_LSB +: 3] = lp;
		result[`SELF_REFRESH_TIMER_LSB +: 4] = sr;
		return result & `POWER_MGMT_CONTROL_MASK;
	endfunction : pm_image

	// Build the priority config image from its three intervals
	function automatic logic [31:0] pr_image(
		input logic [7:0] c1,
		input logic [7:0] c2,
		input logic [7:0] old
	);
		logic [31:0] result;
		result = 32'h0000_0000;
		result[`CLASS1_LSB +: 8] = c1;
		result[`CLASS2_LSB +: 8] = c2;
		result[`OLDEST_LSB +: 8] = old;
		return result & `PRIORITY_RAISE_CONFIG_MASK;
	endfunction : pr_image

	// Select the read image of the addressed register
	function automatic logic [31:0] read_image(
		input logic pm,
		input logic pr,
		input logic [31:0] pm_val,
		input logic [31:0] pr_val
	);
		logic [31:0] result;
		result = 32'h0000_0000;
		if (pm) begin
			result = pm_val;
		end else if (pr) begin
			result = pr_val;
		end
		return result;
	endfunction : read_image

	// True once the idle count covers the coded delay
	function automatic logic idle_done(
		input idle_count_t count,
		input idle_count_t limit
	);
		logic result;
		result = 1'b0;
		if (limit == 19'h00000) begin
			result = 1'b1;
		end else if (count >= limit - 19'h00001) begin
			result = 1'b1;
		end
		return result;
	endfunction : idle_done

	// Register access decode
	assign hit_pm = offset_hit(paddr, `POWER_MGMT_CONTROL_OFFSET);
	assign hit_pr = offset_hit(paddr, `PRIORITY_RAISE_CONFIG_OFFSET);
	assign wr_en = psel && penable && pwrite;
	assign rd_en = psel && !pwrite;
	assign setup_read = rd_en && !penable;
	assign pm_write = wr_en && hit_pm;
	assign pr_write = wr_en && hit_pr;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !(hit_pm || hit_pr);

	// Register images and merged write values
	assign power_mgmt_control = pm_image(power_down_timer, low_power_select, self_refresh_idle_timer);
	assign priority_raise_config = pr_image(class1_raise_interval, class2_raise_interval,
		oldest_raise_interval);
	assign pm_merged = merge_write(power_mgmt_control, pwdata, pstrb, `POWER_MGMT_CONTROL_MASK);
	assign pr_merged = merge_write(priority_raise_config, pwdata, pstrb, `PRIORITY_RAISE_CONFIG_MASK);

	// Power-down delay code, kept for software only
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			power_down_timer <= `POWER_DOWN_TIMER_RESET;
		end else if (pm_write) begin
			power_down_timer <= pm_merged[`POWER_DOWN_TIMER_LSB +: 4];
		end
	end

	// Low-power select
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			low_power_select <= `LOW_POWER_SELECT_RESET;
		end else if (pm_write) begin
			low_power_select <= pm_merged[`LP_SEL_LSB +: 3];
		end
	end

	// Self-refresh idle code
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			self_refresh_idle_timer <= `SELF_REFRESH_TIMER_RESET;
		end else if (pm_write) begin
			self_refresh_idle_timer <= pm_merged[`SELF_REFRESH_TIMER_LSB +: 4];
		end
	end

	// Class-1 interval
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			class1_raise_interval <= `RAISE_INTERVAL_RESET;
		end else if (pr_write) begin
			class1_raise_interval <= pr_merged[`CLASS1_LSB +: 8];
		end
	end

	// Class-2 interval
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			class2_raise_interval <= `RAISE_INTERVAL_RESET;
		end else if (pr_write) begin
			class2_raise_interval <= pr_merged[`CLASS2_LSB +: 8];
		end
	end

	// Oldest-command interval
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			oldest_raise_interval <= `RAISE_INTERVAL_RESET;
		end else if (pr_write) begin
			oldest_raise_interval <= pr_merged[`OLDEST_LSB +: 8];
		end
	end

	// Read data, loaded in the setup cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (setup_read) begin
			prdata <= read_image(hit_pm, hit_pr, power_mgmt_control, priority_raise_config);
		end
	end

	assign sr_selected = (low_power_select == `LP_SELF_REFRESH);
	assign idle_limit = idle_clocks(self_refresh_idle_timer);

	always_comb begin
		next_sr_state = sr_state;
		case (sr_state)
			sr_active: begin
				if (sr_selected && controller_idle) begin
					next_sr_state = (idle_limit == 19'h00000) ? sr_in_self_refresh : sr_counting;
				end
			end
			sr_counting: begin
				if (!sr_selected || !controller_idle) begin
					next_sr_state = sr_active;
				end else if (idle_done(idle_count, idle_target)) begin
					next_sr_state = sr_in_self_refresh;
				end
			end
			sr_in_self_refresh: begin
				if (!sr_selected || !controller_idle) begin
					next_sr_state = sr_active;
				end
			end
			default: begin
				next_sr_state = sr_active;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sr_state <= sr_active;
		end else begin
			sr_state <= next_sr_state;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			idle_count <= 19'h00000;
		end else if (sr_state == sr_counting && next_sr_state == sr_counting) begin
			idle_count <= idle_count + 19'h00001;
		end else begin
			idle_count <= 19'h00001;
		end
	end

	// Delay captured when counting starts, so a code change cannot strand the count
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			idle_target <= 19'h00000;
		end else if (sr_state != sr_counting) begin
			idle_target <= idle_limit;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			self_refresh_req <= 1'b0;
		end else begin
			self_refresh_req <= (next_sr_state == sr_in_self_refresh);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			power_down_sel <= 1'b0;
		end else begin
			power_down_sel <= (low_power_select == `LP_POWER_DOWN);
		end
	end

	raise_timer u_class1 (
		.pclk(pclk),
		.presetn(presetn),
		.interval(class1_raise_interval),
		.raise(class1_raise)
	);

	raise_timer u_class2 (
		.pclk(pclk),
		.presetn(presetn),
		.interval(class2_raise_interval),
		.raise(class2_raise)
	);

	raise_timer u_oldest (
		.pclk(pclk),
		.presetn(presetn),
		.interval(oldest_raise_interval),
		.raise(oldest_raise)
	);
endmodule : idle_priority_timers

/* test/idle_priority_timers_asserts.sv */
// Port checker for the idle and priority timer block.
// Assumes one pclk domain; bound to every idle_priority_timers instance.
`timescale 1ns/1ps
module idle_priority_timers_asserts (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic controller_idle,
	input wire logic self_refresh_req,
	input wire logic class1_raise,
	input wire logic class2_raise,
	input wire logic oldest_raise
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire logic acc = psel && penable;
	wire logic mapped = paddr == 12'h000 || paddr == 12'h004;
	sequence s_quiet(sig);
		!sig [*8];
	endsequence
	a_ready_high: assert property (pready)
		else $error("pready low");
	a_err_unmapped: assert property (acc && !mapped |-> pslverr)
		else $error("no error on unmapped access");
	a_err_mapped: assert property (acc && mapped |-> !pslverr)
		else $error("error on mapped access");
	a_sr_drop: assert property (!controller_idle |=> !self_refresh_req)
		else $error("self-refresh held without idle");
	a_sr_cause: assert property ($rose(self_refresh_req) |-> $past(controller_idle))
		else $error("self-refresh without idle");
	a_class1_gap: assert property (class1_raise |=> s_quiet(class1_raise))
		else $error("class1 raise too soon");
	a_class2_gap: assert property (class2_raise |=> s_quiet(class2_raise))
		else $error("class2 raise too soon");
	a_oldest_gap: assert property (oldest_raise |=> s_quiet(oldest_raise))
		else $error("oldest raise too soon");
	a_rdata_hold: assert property ($changed(prdata) |-> $past(psel && !penable && !pwrite))
		else $error("read data changed outside a read");
endmodule : idle_priority_timers_asserts

bind idle_priority_timers idle_priority_timers_asserts idle_priority_timers_asserts_i (.*);

/* test/command_source.sv */
// Model of the bus masters feeding commands: gives the idle level.
// Assumes the bench raises pending while traffic is queued.
`timescale 1ns/1ps
module command_source (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic pending,
	output logic controller_idle
);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			controller_idle <= 1'b0;
		end else begin
			controller_idle <= !pending;
		end
	end
endmodule : command_source

/* test/idle_priority_timers_tb.sv */
// Testbench for the idle and priority timer block over APB.
// Assumes zero-wait APB slave at 0x000 and 0x004.
`timescale 1ns/1ps
module idle_priority_timers_tb;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic pending = 1'b1;
	logic er;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] rd;
	logic [31:0] n;
	wire logic [31:0] prdata;
	wire logic pready, pslverr, controller_idle, self_refresh_req, power_down_sel;
	wire logic [2:0] rz;
	int err_count = 0;
	int check_count = 0;
	int cyc = 0;
	always #2 pclk = ~pclk;
	idle_priority_timers idle_priority_timers_i (.*, .pstrb(4'hF), .class1_raise(rz[0]), .class2_raise(rz[1]),
		.oldest_raise(rz[2]));
	command_source command_source_i (.*);
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic gap(input int k);
		for (n = 0; rz[k] !== 1'b1 && n < 5000; n++) @(posedge pclk);
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (rz[k] !== 1'b1 && n < 5000);
	endtask : gap
	task automatic report_and_stop;
		$display("checks %0d errors %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : report_and_stop
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			err_count++;
			report_and_stop;
		end
	end
	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, 12'h000, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, 12'h004, 32'h0);
		chk(rd, 32'h00FF_FFFF);
		apb(1'b1, 12'h004, 32'hFFFF_FFFF);
		apb(1'b0, 12'h004, 32'h0);
		chk(rd, 32'h00FF_FFFF);
		apb(1'b1, 12'h000, 32'hFFFF_FFFF);
		apb(1'b0, 12'h000, 32'h0);
		chk(rd, 32'h0000_F7F0);
		apb(1'b0, 12'h008, 32'h0);
		chk(er, 32'h1);
		chk(rd, 32'h0);
		apb(1'b1, 12'h004, 32'h0001_0203);
		for (int k = 0; k < 3; k++) begin
			gap(k);
			chk(n, 16 * (k + 1));
		end
		apb(1'b1, 12'h000, 32'h0000_0210);
		pending <= 1'b0;
		repeat (15) @(posedge pclk);
		chk(self_refresh_req, 32'h0);
		for (n = 0; self_refresh_req !== 1'b1 && n < 6; n++) @(posedge pclk);
		chk(self_refresh_req, 32'h1);
		pending <= 1'b1;
		repeat (3) @(posedge pclk);
		chk(self_refresh_req, 32'h0);
		apb(1'b1, 12'h000, 32'h0000_0200);
		pending <= 1'b0;
		repeat (4) @(posedge pclk);
		chk(self_refresh_req, 32'h1);
		apb(1'b1, 12'h000, 32'h0000_0300);
		repeat (20) @(posedge pclk);
		chk({self_refresh_req, power_down_sel}, 32'h0);
		apb(1'b1, 12'h000, 32'h0000_0400);
		repeat (3) @(posedge pclk);
		chk({self_refresh_req, power_down_sel}, 32'h1);
		pending <= 1'b1;
		repeat (3) @(posedge pclk);
		apb(1'b1, 12'h000, 32'h0000_02A0);
		pending <= 1'b0;
		repeat (8911) @(posedge pclk);
		chk(self_refresh_req, 32'h0);
		for (n = 0; self_refresh_req !== 1'b1 && n < 6; n++) @(posedge pclk);
		chk(self_refresh_req, 32'h1);
		report_and_stop;
	end
endmodule : idle_priority_timers_tb
